// [common/canid_pkg.sv]
// constants and types of the message buffer identifier block
package canid_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_TX_B0 = 6'h00;
  localparam logic [5:0] IDX_TX_B1 = 6'h01;
  localparam logic [5:0] IDX_TX_B2 = 6'h02;
  localparam logic [5:0] IDX_TX_B3 = 6'h03;
  localparam logic [5:0] IDX_RX_B0 = 6'h04;
  localparam logic [5:0] IDX_RX_B3 = 6'h07;
  localparam logic [5:0] IDX_SEL   = 6'h08;
  localparam logic [5:0] IDX_CMD   = 6'h09;
  localparam logic [5:0] IDX_STAT  = 6'h0A;
  // field positions
  localparam int B1_SRR     = 4;
  localparam int B1_IDE     = 3;
  localparam int B1_STD_RTR = 4;
  localparam int B3_RTR     = 0;
  localparam int CMD_TX_REQ = 0;
  localparam int CMD_RX_REL = 1;
  // reset values
  localparam logic EMPTY_RST = 1'b1;
  localparam logic FULL_RST  = 1'b0;
  localparam logic SEL_RST   = 1'b0;
  // arbitration field lengths and receive bit counts
  localparam logic [5:0] EXT_LEN      = 6'h20;
  localparam logic [5:0] STD_LEN      = 6'h0D;
  localparam logic [4:0] STD_LAST_CNT = 5'h0C;
  localparam logic [4:0] EXT_LAST_CNT = 5'h1F;
  localparam int BIT_CYCLES_DEF = 20;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_ARB  = 2'b10
  } tx_state_e;
  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } rx_state_e;
endpackage

// [common/arb_if.sv]
// carrier between the buffer control and the arbitration field shifter
interface arb_if;
  logic        load;
  logic [28:0] id;
  logic        srr;
  logic        ide;
  logic        rtr;
  logic        shift;
  logic        bit_out;
  logic [5:0]  left;
  modport ctrl (output load, id, srr, ide, rtr, shift, input bit_out, left);
  modport shifter (input load, id, srr, ide, rtr, shift, output bit_out, left);
endinterface

// [rtl/arb_shifter.sv]
// serialiser of the identifier arbitration field, most significant first
module arb_shifter (
  input wire logic clk,
  input wire logic srst,
  arb_if.shifter   a
);
  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic [5:0]  left_ff;
  logic [5:0]  nxt_left;
  logic        ide_q_ff;
  logic        rtr_q_ff;

  always_comb begin
    nxt_sh   = sh_ff;
    nxt_left = left_ff;
    if (a.load) begin
      if (a.ide) begin
        nxt_sh   = {a.id[28:18], a.srr, a.ide, a.id[17:0], a.rtr};
        nxt_left = canid_pkg::EXT_LEN;
      end else begin
        nxt_sh   = {a.id[10:0], a.rtr, a.ide, 19'h0};
        nxt_left = canid_pkg::STD_LEN;
      end
    end else if (a.shift && left_ff != 6'h00) begin
      nxt_sh   = {sh_ff[30:0], 1'b0};
      nxt_left = left_ff - 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sh_ff    <= 32'h0;
      left_ff  <= 6'h00;
      ide_q_ff <= 1'b0;
      rtr_q_ff <= 1'b0;
    end else begin
      sh_ff   <= nxt_sh;
      left_ff <= nxt_left;
      if (a.load) begin
        ide_q_ff <= a.ide;
        rtr_q_ff <= a.rtr;
      end
    end
  end

  assign a.bit_out = sh_ff[31];
  assign a.left    = left_ff;

  ////////////////////////////////////////////////////////////////////////////////
  a_ext_len: assert property (@(posedge clk) disable iff (srst)
    a.load && a.ide |=> left_ff == 6'h20)
    else $error("extended field not 32 bits");
  a_std_len: assert property (@(posedge clk) disable iff (srst)
    a.load && !a.ide |=> left_ff == 6'h0D)
    else $error("standard field not 13 bits");
  a_ext_msb: assert property (@(posedge clk) disable iff (srst)
    a.load && a.ide |=> a.bit_out == $past(a.id[28]))
    else $error("extended identifier msb not first");
  a_std_msb: assert property (@(posedge clk) disable iff (srst)
    a.load && !a.ide |=> a.bit_out == $past(a.id[10]))
    else $error("standard identifier msb not first");
  a_last_bit: assert property (@(posedge clk) disable iff (srst)
    left_ff == 6'h01 |-> sh_ff[31] == (ide_q_ff ? rtr_q_ff : 1'b0))
    else $error("field does not end with rtr or ide");
  a_std_rtr: assert property (@(posedge clk) disable iff (srst)
    left_ff == 6'h02 && !ide_q_ff |-> sh_ff[31] == rtr_q_ff)
    else $error("standard rtr bit misplaced");
endmodule // arb_shifter

// [rtl/canid_msgbuf.sv]
// identifier bytes of one transmit and one receive message buffer, apb slave
// What this block does
// - extended identifier group holds 29 id bits plus srr, ide and rtr
// - standard identifier group holds 11 id bits plus rtr and ide
// - extended identifier is 29 bits, bit 28 sent first
// - smallest identifier wins; a sent one overwritten by zero loses
// - standard identifier is 11 bits, bit 10 sent first
// - extended byte0 id28..21; byte1 id20..18, srr, ide, id17..15
// - extended byte2 id14..7; byte3 id6..0 then rtr
// - standard byte0 id10..3; byte1 id2..0, rtr, ide zero
// - software sets srr in transmit; receive stores srr as seen
// - transmit sends extended identifier when ide set, else standard
// - receive writes ide from the received frame format
// - transmit rtr zero sends data frame, one sends remote frame
// - receive stores the received rtr bit
// - unused standard layout bits read undefined
// - transmit bytes accessible only when empty and selected
// - receive bytes readable only when full; writes ignored
module canid_msgbuf #(
  parameter int BIT_CYCLES = canid_pkg::BIT_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        can_rx,
  output logic             can_tx
);
  ////////////////////////////////////////////////////////////////////////////////
  // bit rate divider and receive pin synchroniser
  logic [15:0] div_ff;
  logic        bit_en_ff;
  logic        rx_meta_ff;
  logic        rx_s_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      div_ff     <= 16'h0000;
      bit_en_ff  <= 1'b0;
      rx_meta_ff <= 1'b1;
      rx_s_ff    <= 1'b1;
    end else begin
      rx_meta_ff <= can_rx;
      rx_s_ff    <= rx_meta_ff;
      if (div_ff == 16'(BIT_CYCLES - 1)) begin
        div_ff    <= 16'h0000;
        bit_en_ff <= 1'b1;
      end else begin
        div_ff    <= div_ff + 16'h0001;
        bit_en_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control state
  logic [31:0]          prdata_ff, nxt_prdata;
  logic                 pready_ff, nxt_pready;
  logic                 pslverr_ff, nxt_pslverr;
  logic                 can_tx_ff, nxt_can_tx;
  logic                 empty_ff, nxt_empty;
  logic                 full_ff, nxt_full;
  logic                 sel_ff, nxt_sel;
  logic                 lost_ff, nxt_lost;
  logic                 sent_ff, nxt_sent;
  canid_pkg::tx_state_e tx_state_ff, nxt_tx_state;
  canid_pkg::rx_state_e rx_state_ff, nxt_rx_state;
  logic [31:0]          rx_sh_ff, nxt_rx_sh;
  logic [4:0]           rx_cnt_ff, nxt_rx_cnt;
  logic [7:0]           tx_id_ff [4];
  logic [7:0]           nxt_tx_id [4];
  logic [7:0]           rx_id_ff [4];
  logic [7:0]           nxt_rx_id [4];
  logic [5:0]           idx;
  logic                 tx_ok;
  logic                 rx_ok;
  logic                 wr_done;
  logic                 tx_load;
  logic                 tx_shift;
  logic                 tx_ide;
  arb_if                arb ();

  assign idx     = paddr[7:2];
  assign tx_ok   = empty_ff & sel_ff;
  assign rx_ok   = full_ff;
  assign wr_done = psel & penable & pready_ff & pwrite & pstrb[0];
  assign tx_ide  = tx_id_ff[1][canid_pkg::B1_IDE];

  // unpack the transmit bytes into the field
  assign arb.load  = tx_load;
  assign arb.shift = tx_shift;
  assign arb.ide   = tx_ide;
  assign arb.srr   = tx_id_ff[1][canid_pkg::B1_SRR];
  assign arb.id    = tx_ide ? {tx_id_ff[0], tx_id_ff[1][7:5], tx_id_ff[1][2:0],
                               tx_id_ff[2], tx_id_ff[3][7:1]}
                            : {18'h00000, tx_id_ff[0], tx_id_ff[1][7:5]};
  assign arb.rtr   = tx_ide ? tx_id_ff[3][canid_pkg::B3_RTR]
                            : tx_id_ff[1][canid_pkg::B1_STD_RTR];

  arb_shifter u_shifter (
    .clk  (clk),
    .srst (srst),
    .a    (arb.shifter)
  );

  always_comb begin
    nxt_prdata   = prdata_ff;
    nxt_pready   = 1'b0;
    nxt_pslverr  = pslverr_ff;
    nxt_can_tx   = can_tx_ff;
    nxt_empty    = empty_ff;
    nxt_full     = full_ff;
    nxt_sel      = sel_ff;
    nxt_lost     = lost_ff;
    nxt_sent     = sent_ff;
    nxt_tx_state = tx_state_ff;
    nxt_rx_state = rx_state_ff;
    nxt_rx_sh    = rx_sh_ff;
    nxt_rx_cnt   = rx_cnt_ff;
    nxt_tx_id    = tx_id_ff;
    nxt_rx_id    = rx_id_ff;
    tx_load      = 1'b0;
    tx_shift     = 1'b0;
    // apb setup cycle: answer is prepared for the first access cycle
    if (psel && !penable) begin
      nxt_pready  = 1'b1;
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (idx <= canid_pkg::IDX_TX_B3) begin
        if (tx_ok) begin
          nxt_prdata = {24'h00_0000, tx_id_ff[idx[1:0]]};
        end else begin
          nxt_pslverr = 1'b1;
        end
      end else if (idx <= canid_pkg::IDX_RX_B3) begin
        if (!pwrite && rx_ok) begin
          nxt_prdata = {24'h00_0000, rx_id_ff[idx[1:0]]};
        end else if (!pwrite) begin
          nxt_pslverr = 1'b1;
        end
      end else if (idx == canid_pkg::IDX_SEL) begin
        nxt_prdata = {31'h0000_0000, sel_ff};
      end else if (idx == canid_pkg::IDX_CMD) begin
        nxt_prdata = 32'h0000_0000;
      end else if (idx == canid_pkg::IDX_STAT) begin
        nxt_prdata = {29'h0000_0000, lost_ff, full_ff, empty_ff};
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
    // apb write takes effect at the completing edge
    if (wr_done) begin
      if (idx <= canid_pkg::IDX_TX_B3) begin
        if (tx_ok) begin
          nxt_tx_id[idx[1:0]] = pwdata[7:0];
        end
      end else if (idx == canid_pkg::IDX_SEL) begin
        nxt_sel = pwdata[0];
      end else if (idx == canid_pkg::IDX_CMD) begin
        if (pwdata[canid_pkg::CMD_TX_REQ] && empty_ff) begin
          nxt_empty    = 1'b0;
          nxt_lost     = 1'b0;
          tx_load      = 1'b1;
          nxt_tx_state = canid_pkg::TX_WAIT;
        end
        if (pwdata[canid_pkg::CMD_RX_REL]) begin
          nxt_full = 1'b0;
        end
      end
    end
    // transmit: start bit then arbitration field
    case (tx_state_ff)
      canid_pkg::TX_WAIT: begin
        if (bit_en_ff) begin
          nxt_can_tx   = 1'b0;
          nxt_sent     = 1'b0;
          nxt_tx_state = canid_pkg::TX_ARB;
        end
      end
      canid_pkg::TX_ARB: begin
        if (bit_en_ff) begin
          if (sent_ff && !rx_s_ff) begin
            nxt_can_tx   = 1'b1;
            nxt_lost     = 1'b1;
            nxt_empty    = 1'b1;
            nxt_tx_state = canid_pkg::TX_IDLE;
          end else if (arb.left == 6'h00) begin
            nxt_can_tx   = 1'b1;
            nxt_empty    = 1'b1;
            nxt_tx_state = canid_pkg::TX_IDLE;
          end else begin
            nxt_can_tx = arb.bit_out;
            nxt_sent   = arb.bit_out;
            tx_shift   = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    // receive: collect the arbitration field of a frame from another node
    case (rx_state_ff)
      canid_pkg::RX_IDLE: begin
        if (bit_en_ff && tx_state_ff == canid_pkg::TX_IDLE && !rx_s_ff) begin
          nxt_rx_state = canid_pkg::RX_BITS;
          nxt_rx_cnt   = 5'h00;
        end
      end
      canid_pkg::RX_BITS: begin
        if (bit_en_ff) begin
          nxt_rx_sh  = {rx_sh_ff[30:0], rx_s_ff};
          nxt_rx_cnt = rx_cnt_ff + 5'h01;
          if (rx_cnt_ff == canid_pkg::STD_LAST_CNT && !rx_s_ff) begin
            nxt_rx_state = canid_pkg::RX_IDLE;
            if (!full_ff) begin
              nxt_full     = 1'b1;
              nxt_rx_id[0] = rx_sh_ff[11:4];
              // low bits of byte 1 keep whatever they held
              nxt_rx_id[1] = {rx_sh_ff[3:1], rx_sh_ff[0], 1'b0, rx_id_ff[1][2:0]};
            end
          end else if (rx_cnt_ff == canid_pkg::EXT_LAST_CNT) begin
            nxt_rx_state = canid_pkg::RX_IDLE;
            if (!full_ff) begin
              nxt_full     = 1'b1;
              nxt_rx_id[0] = rx_sh_ff[30:23];
              nxt_rx_id[1] = {rx_sh_ff[22:20], rx_sh_ff[19], rx_sh_ff[18],
                              rx_sh_ff[17:15]};
              nxt_rx_id[2] = rx_sh_ff[14:7];
              nxt_rx_id[3] = {rx_sh_ff[6:0], rx_s_ff};
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff   <= 32'h0000_0000;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
      can_tx_ff   <= 1'b1;
      empty_ff    <= canid_pkg::EMPTY_RST;
      full_ff     <= canid_pkg::FULL_RST;
      sel_ff      <= canid_pkg::SEL_RST;
      lost_ff     <= 1'b0;
      sent_ff     <= 1'b0;
      tx_state_ff <= canid_pkg::TX_IDLE;
      rx_state_ff <= canid_pkg::RX_IDLE;
      rx_sh_ff    <= 32'h0000_0000;
      rx_cnt_ff   <= 5'h00;
    end else begin
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
      can_tx_ff   <= nxt_can_tx;
      empty_ff    <= nxt_empty;
      full_ff     <= nxt_full;
      sel_ff      <= nxt_sel;
      lost_ff     <= nxt_lost;
      sent_ff     <= nxt_sent;
      tx_state_ff <= nxt_tx_state;
      rx_state_ff <= nxt_rx_state;
      rx_sh_ff    <= nxt_rx_sh;
      rx_cnt_ff   <= nxt_rx_cnt;
    end
  end

  // buffer storage holds no reset value
  always_ff @(posedge clk) begin
    tx_id_ff <= nxt_tx_id;
    rx_id_ff <= nxt_rx_id;
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign can_tx  = can_tx_ff;

  ////////////////////////////////////////////////////////////////////////////////
  a_tx_gated: assert property (@(posedge clk) disable iff (srst)
    psel && !penable && idx <= 6'h03 && !(empty_ff && sel_ff) |=> pready && pslverr)
    else $error("transmit byte access not refused");
  a_rx_no_write: assert property (@(posedge clk) disable iff (srst)
    wr_done && idx >= 6'h04 && idx <= 6'h07 && full_ff
    |=> {rx_id_ff[0], rx_id_ff[1], rx_id_ff[2], rx_id_ff[3]}
        == $past({rx_id_ff[0], rx_id_ff[1], rx_id_ff[2], rx_id_ff[3]}))
    else $error("receive byte changed by write");
  a_rx_read_gate: assert property (@(posedge clk) disable iff (srst)
    psel && !penable && !pwrite && idx >= 6'h04 && idx <= 6'h07 && !full_ff
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("receive byte read while not full");
  a_arb_lost: assert property (@(posedge clk) disable iff (srst)
    tx_state_ff == canid_pkg::TX_ARB && bit_en_ff && sent_ff && !rx_s_ff
    |=> lost_ff && empty_ff && can_tx && tx_state_ff == canid_pkg::TX_IDLE)
    else $error("recessive bit overwritten without losing");
  a_rx_ide_fmt: assert property (@(posedge clk) disable iff (srst)
    $rose(full_ff) && rx_state_ff == canid_pkg::RX_IDLE
    |-> rx_id_ff[1][3] == ($past(rx_cnt_ff) == 5'h1F))
    else $error("stored ide does not match frame format");
  a_rx_rtr_ext: assert property (@(posedge clk) disable iff (srst)
    $rose(full_ff) && $past(rx_cnt_ff) == 5'h1F |-> rx_id_ff[3][0] == $past(rx_s_ff))
    else $error("received rtr not stored");
  a_tx_sof: assert property (@(posedge clk) disable iff (srst)
    tx_state_ff == canid_pkg::TX_WAIT && bit_en_ff |=> !can_tx ##1 !can_tx[*3])
    else $error("start bit not dominant");
  a_tx_srr: assert property (@(posedge clk) disable iff (srst)
    tx_state_ff == canid_pkg::TX_ARB && tx_ide && arb.left == 6'h15
    |-> arb.bit_out == tx_id_ff[1][canid_pkg::B1_SRR])
    else $error("srr not sent right after id18");
  // access protocol, bit grid, receive full flag and transmit sequencing
  a_pready_once: assert property (@(posedge clk) disable iff (srst)
    pready |=> !pready)
    else $error("pready longer than one cycle");
  a_upper_zero: assert property (@(posedge clk) disable iff (srst)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data above the byte not zero");
  a_bit_grid: assert property (@(posedge clk) disable iff (srst)
    bit_en_ff |=> !bit_en_ff)
    else $error("bit enable longer than one cycle");
  a_tx_wr_drop: assert property (@(posedge clk) disable iff (srst)
    wr_done && idx <= 6'h03 && !tx_ok
    |=> {tx_id_ff[0], tx_id_ff[1], tx_id_ff[2], tx_id_ff[3]}
        == $past({tx_id_ff[0], tx_id_ff[1], tx_id_ff[2], tx_id_ff[3]}))
    else $error("refused transmit write changed a byte");
  a_busy_state: assert property (@(posedge clk) disable iff (srst)
    !empty_ff |-> tx_state_ff != canid_pkg::TX_IDLE)
    else $error("buffer busy with transmitter idle");
  a_full_hold: assert property (@(posedge clk) disable iff (srst)
    full_ff && !(wr_done && idx == canid_pkg::IDX_CMD && pwdata[canid_pkg::CMD_RX_REL])
    |=> full_ff)
    else $error("receive full flag dropped without release");
  a_tx_end: assert property (@(posedge clk) disable iff (srst)
    tx_state_ff == canid_pkg::TX_ARB && bit_en_ff && arb.left == 6'h00
    |=> can_tx && empty_ff && tx_state_ff == canid_pkg::TX_IDLE)
    else $error("bus not released after the last field bit");
  a_tx_recessive: assert property (@(posedge clk) disable iff (srst)
    tx_state_ff != canid_pkg::TX_ARB |-> can_tx)
    else $error("dominant level outside arbitration");
endmodule // canid_msgbuf

// [testbench/can_node.sv]
// far-side bus node: wired bus, bit grid tracking, frame sender and bit capture
module can_node #(
  parameter int BC = 8
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        can_tx,
  input  wire logic        arm,
  output logic             can_rx,
  output logic      [31:0] cap_ff,
  output logic      [5:0]  ncap_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MID = 2;
  logic node_tx;
  logic prev_ff;
  logic busy_ff;
  int   cnt_ff;

  // dominant zero wins the shared line
  assign can_rx = can_tx & node_tx;

  initial node_tx = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // bit grid follows the edges of can_tx; capture starts with the bit after the first dominant bit
  always_ff @(posedge clk) begin
    prev_ff <= can_tx;
    if (srst) begin
      cnt_ff <= 0;
    end else if (can_tx != prev_ff) begin
      cnt_ff <= 1;
    end else begin
      cnt_ff <= (cnt_ff == BC - 1) ? 0 : cnt_ff + 1;
    end
    if (arm) begin
      busy_ff <= 1'b0;
      ncap_ff <= 6'h00;
    end else if (cnt_ff == MID) begin
      if (!busy_ff) begin
        busy_ff <= !can_rx;
      end else if (ncap_ff < 6'h20) begin
        cap_ff  <= {cap_ff[30:0], can_rx};
        ncap_ff <= ncap_ff + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start of frame, then n bits msb first, then recessive; optionally joins a frame
  // bits change one clock before the capture point, so the capture sees them
  task automatic send(input logic [31:0] bits, input int n, input logic join_tx);
    int i;
    int w;
    i = -1;
    w = 0;
    while (join_tx && can_tx !== 1'b0 && w < 2000) begin
      @(posedge clk);
      w++;
    end
    while (i <= n) begin
      @(posedge clk);
      if (cnt_ff == MID - 1) begin
        node_tx <= (i < 0) ? 1'b0 : (i < n) ? bits[31 - i] : 1'b1;
        i++;
      end
    end
  endtask
endmodule // can_node

// [testbench/tb_top.sv]
// top testbench: apb master tasks and identifier buffer scenarios
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 8;
  logic        clk;
  logic        srst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        can_rx;
  logic        can_tx;
  logic        arm;
  logic [31:0] cap;
  logic [5:0]  ncap;
  logic [31:0] rd;
  logic        err;
  int          miscompares;
  int          num_checks;

  canid_msgbuf #(.BIT_CYCLES(BC)) canid_msgbuf_i (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .can_tx(can_tx));
  can_node #(.BC(BC)) can_node_i (.clk(clk), .srst(srst), .can_tx(can_tx), .arm(arm),
    .can_rx(can_rx), .cap_ff(cap), .ncap_ff(ncap));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer, entered just after a rising edge, left one edge after release
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    int w;
    w = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && w < 100) begin
      @(posedge clk);
      w++;
    end
    if (w >= 100) begin
      miscompares++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string name, input logic [5:0] idx, input logic [31:0] mask,
                     input logic [31:0] exp, input logic experr);
    apb(1'b0, idx, 32'h0);
    chk_word(name, exp, rd & mask);
    chk_bit(name, experr, err);
  endtask

  task automatic wrc(input logic [5:0] idx, input logic [31:0] wd, input logic experr);
    apb(1'b1, idx, wd);
    chk_bit("write error", experr, err);
  endtask

  task automatic put_bytes(input logic [31:0] b);
    for (int i = 0; i < 4; i++) wrc(canid_pkg::IDX_TX_B0 + 6'(i), {24'h0, b[31-8*i -: 8]}, 1'b0);
  endtask

  task automatic chk_bytes(input string name, input logic [5:0] base, input logic [31:0] b,
                           input logic [31:0] m);
    for (int i = 0; i < 4; i++) begin
      rdc(name, base + 6'(i), {24'h0, m[31-8*i -: 8]}, {24'h0, b[31-8*i -: 8] & m[31-8*i -: 8]},
          1'b0);
    end
  endtask

  task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
    int w;
    w = 0;
    apb(1'b0, canid_pkg::IDX_STAT, 32'h0);
    while ((rd & mask) !== val && w < 200) begin
      apb(1'b0, canid_pkg::IDX_STAT, 32'h0);
      w++;
    end
    chk_word("status", val, rd & mask);
  endtask

  task automatic wait_cap(input logic [31:0] exp);
    int w;
    w = 0;
    while (ncap !== 6'h20 && w < 1000) begin
      @(posedge clk);
      w++;
    end
    chk_word("capture count", 32'h20, {26'h0, ncap});
    chk_word("bus bits", exp, cap);
  endtask

  task automatic tx_frame(input logic [31:0] exp);
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    wrc(canid_pkg::IDX_CMD, 32'h1, 1'b0);
    rdc("busy tx byte", canid_pkg::IDX_TX_B0, 32'hFF, 32'h0, 1'b1);
    wrc(canid_pkg::IDX_TX_B0, 32'h0, 1'b1);
    wait_cap(exp);
    wait_stat(32'h1, 32'h1);
    rdc("tx byte kept", canid_pkg::IDX_TX_B0, 32'hFF, {24'h0, exp[31:24]}, 1'b0);
  endtask

  // byte layout equals the serial field order
  function automatic logic [31:0] ext_f(input logic [28:0] id, input logic srr, input logic rtr);
    return {id[28:18], srr, 1'b1, id[17:0], rtr};
  endfunction

  function automatic logic [31:0] std_f(input logic [10:0] id, input logic rtr);
    return {id, rtr, 1'b0, 19'h7FFFF};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    arm = 1'b1;
    miscompares = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rdc("status", canid_pkg::IDX_STAT, 32'h7, 32'h1, 1'b0);
    rdc("tx unselected", canid_pkg::IDX_TX_B0, 32'hFF, 32'h0, 1'b1);
    rdc("unmapped", 6'h3F, 32'hFFFFFFFF, 32'h0, 1'b1);
    rdc("rx not full", canid_pkg::IDX_RX_B0, 32'hFF, 32'h0, 1'b1);
    wrc(canid_pkg::IDX_SEL, 32'h1, 1'b0);
    put_bytes(ext_f(29'h12345678, 1'b1, 1'b0));
    chk_bytes("tx ext", canid_pkg::IDX_TX_B0, ext_f(29'h12345678, 1'b1, 1'b0), '1);
    tx_frame(ext_f(29'h12345678, 1'b1, 1'b0));
    put_bytes(std_f(11'h5A3, 1'b1));
    chk_bytes("tx std", canid_pkg::IDX_TX_B0, std_f(11'h5A3, 1'b1), 32'hFFF80000);
    tx_frame(std_f(11'h5A3, 1'b1));
    pstrb <= 4'hE;
    wrc(canid_pkg::IDX_TX_B0, 32'h0, 1'b0);
    pstrb <= 4'hF;
    rdc("strobe off", canid_pkg::IDX_TX_B0, 32'hFF, 32'h000000B4, 1'b0);
    can_node_i.send(ext_f(29'h0F0F1234, 1'b0, 1'b1), 32, 1'b0);
    wait_stat(32'h2, 32'h2);
    chk_bytes("rx ext", canid_pkg::IDX_RX_B0, ext_f(29'h0F0F1234, 1'b0, 1'b1), '1);
    wrc(canid_pkg::IDX_RX_B0, 32'h000000FF, 1'b0);
    rdc("rx after write", canid_pkg::IDX_RX_B0, 32'hFF, 32'h00000078, 1'b0);
    wrc(canid_pkg::IDX_CMD, 32'h2, 1'b0);
    wait_stat(32'h2, 32'h0);
    can_node_i.send(std_f(11'h2C7, 1'b0), 13, 1'b0);
    wait_stat(32'h2, 32'h2);
    chk_bytes("rx std", canid_pkg::IDX_RX_B0, std_f(11'h2C7, 1'b0), 32'hFFF80000);
    wrc(canid_pkg::IDX_CMD, 32'h2, 1'b0);
    wait_stat(32'h2, 32'h0);
    put_bytes(ext_f(29'h15555555, 1'b1, 1'b0));
    arm <= 1'b1;
    @(posedge clk);
    arm <= 1'b0;
    wrc(canid_pkg::IDX_CMD, 32'h1, 1'b0);
    can_node_i.send(ext_f(29'h15555554, 1'b1, 1'b0), 32, 1'b1);
    wait_stat(32'h5, 32'h5);
    wait_cap(ext_f(29'h15555554, 1'b1, 1'b0));
    chk_bit("tx released", 1'b1, can_tx);
    end_of_test();
  end
endmodule // tb_top
